// ---- esb_pkg.sv ----
// ----------------------------------------
// Shared constants and types
// ----------------------------------------
package esb_pkg;
  localparam int NPT = 8;
  localparam int PW = 3;
  localparam int VW = 16;
  localparam int NPART = 2;
  localparam int DEPTH = 32;
  localparam int AW = 5;
  localparam int CW = 6;
  localparam int ADW = 8;
  localparam int JW = 4;
  localparam int IW = 8;
  localparam int OW = 13;
  localparam logic [PW:0] NPT_CNT = 4'h8;
  localparam logic [PW-1:0] LAST_PT = 3'h7;
  // Controller memory windows: point values, write targets, trigger tags
  localparam logic [ADW-1:0] RD_BASE = 8'h00;
  localparam logic [ADW-1:0] WR_BASE = 8'h40;
  localparam logic [ADW-1:0] TAG_BASE = 8'h80;
  // Send buffer share per partner, one or two partners enabled
  localparam logic [CW-1:0] SHARE_ONE = 6'h20;
  localparam logic [CW-1:0] SHARE_TWO = 6'h10;
  // Fill levels in percent
  localparam logic [OW-1:0] PCT_ALL = 13'h0064;
  localparam logic [OW-1:0] PCT_FULL = 13'h005a;
  localparam logic [OW-1:0] PCT_REL = 13'h0050;
  localparam logic [OW-1:0] PCT_LOW = 13'h0032;
  // Timebase
  localparam int CLK_HZ = 40_000_000;
  localparam int TB_MS = 500;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / MS_PER_S * TB_MS;
  typedef enum logic [1:0] {TRG_THR, TRG_TIME, TRG_EDGE, TRG_OFF} esb_trig_t;
  typedef enum logic [1:0] {PH_FAST, PH_WRITE, PH_NORM, PH_IDLE} esb_phase_t;
endpackage

// ---- esb_top.sv ----
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module esb_top #(
  parameter int TICK_CYC = esb_pkg::TICK_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [esb_pkg::NPT-1:0] static_cfg,
  input wire logic [esb_pkg::NPT-1:0] every_cfg,
  input wire logic [esb_pkg::NPT-1:0] spont_cfg,
  input wire logic [esb_pkg::NPT-1:0] fast_cfg,
  input wire logic [esb_pkg::NPT-1:0] tag_mem_cfg,
  input wire logic [2*esb_pkg::NPT-1:0] trg_cfg,
  input wire logic [esb_pkg::VW-1:0] thr_cfg,
  input wire logic [esb_pkg::IW-1:0] tper_cfg,
  input wire logic tod_hit,
  input wire logic [esb_pkg::JW-1:0] max_wr_cfg,
  input wire logic [esb_pkg::JW-1:0] max_rd_cfg,
  input wire logic [esb_pkg::IW-1:0] idle_cfg,
  input wire logic [esb_pkg::NPT-1:0] trig_tag,
  input wire logic wr_req,
  input wire logic [esb_pkg::PW-1:0] wr_pt,
  input wire logic [esb_pkg::VW-1:0] wr_val,
  output logic [esb_pkg::ADW-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [esb_pkg::VW-1:0] mem_wdata,
  input wire logic [esb_pkg::VW-1:0] mem_rdata,
  input wire logic [esb_pkg::NPART-1:0] part_en,
  input wire logic [esb_pkg::NPART-1:0] link_up,
  input wire logic [esb_pkg::NPART-1:0] query,
  output logic tx_valid,
  output logic tx_part,
  output logic tx_kind,
  output logic [esb_pkg::PW-1:0] tx_pt,
  output logic [esb_pkg::VW-1:0] tx_val,
  input wire logic tx_ack,
  output logic [esb_pkg::NPART-1:0] forced_mode,
  output logic tick
);
  import esb_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PW-1:0] first1(input logic [NPT-1:0] v);
    logic [PW-1:0] r;
    r = '0;
    for (int i = NPT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PW'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] phys(input logic q, input logic [AW-1:0] p, input logic two);
    return two ? {q, p[AW-2:0]} : p;
  endfunction

  function automatic logic [AW-1:0] incp(input logic [AW-1:0] p, input logic [CW-1:0] sh);
    logic [CW-1:0] n;
    n = {1'b0, p} + 6'h01;
    return (n == sh) ? '0 : n[AW-1:0];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  esb_phase_t ph_r;
  logic [PW:0] idx_r;
  logic [JW-1:0] jobs_r;
  logic [PW-1:0] nptr_r;
  logic [IW-1:0] idle_r;
  logic rd_v_r;
  logic [PW-1:0] rd_pt_r;
  logic [31:0] tick_cnt_r;
  logic [IW-1:0] tper_r;
  logic [VW-1:0] img_r [NPT];
  logic [VW-1:0] last_r [NPT];
  logic [VW-1:0] wr_val_r [NPT];
  logic [NPT-1:0] tag_q_r, edge_due_r, time_due_r, clr_pend_r, wr_pend_r;
  logic [VW-1:0] bval_r [DEPTH];
  logic [PW-1:0] bpt_r [DEPTH];
  logic [AW-1:0] head_r [NPART];
  logic [AW-1:0] tail_r [NPART];
  logic [CW-1:0] cnt_r [NPART];
  logic [NPT-1:0] cv_in_r [NPART];
  logic [AW-1:0] cv_slot_r [NPART][NPT];
  logic [NPART-1:0] forced_r, rel_r, img_pend_r;
  logic [PW-1:0] img_idx_r [NPART];

  // ----------------------------------------
  // Scan decode
  // ----------------------------------------
  wire logic clr_any = |clr_pend_r;
  wire logic [PW-1:0] clr_sel = first1(clr_pend_r);
  wire logic [PW-1:0] wr_sel = first1(wr_pend_r);
  wire logic fast_end = (idx_r == NPT_CNT);
  // Compare with >= so a quota lowered mid-scan still ends the phase
  wire logic norm_end = (idx_r == NPT_CNT) || (jobs_r >= max_rd_cfg);
  wire logic clr_go = (ph_r == PH_WRITE) && clr_any;
  // Tag clears ride ahead of the job quota so they never starve
  wire logic wr_go = (ph_r == PH_WRITE) && !clr_any && (|wr_pend_r) && (jobs_r < max_wr_cfg);
  wire logic fast_rd = (ph_r == PH_FAST) && !fast_end && fast_cfg[idx_r[PW-1:0]];
  wire logic norm_rd = (ph_r == PH_NORM) && !norm_end && !fast_cfg[nptr_r];
  wire logic rd_go = fast_rd || norm_rd;
  wire logic [PW-1:0] rd_pt_w = fast_rd ? idx_r[PW-1:0] : nptr_r;

  // ----------------------------------------
  // Save decision on returning read data
  // ----------------------------------------
  wire logic [PW-1:0] p = rd_pt_r;
  wire logic [VW-1:0] v = mem_rdata;
  wire esb_trig_t trg_w = esb_trig_t'(trg_cfg[2*p +: 2]);
  wire logic [VW-1:0] dev = (v >= last_r[p]) ? v - last_r[p] : last_r[p] - v;
  wire logic thr_hit = (trg_w == TRG_THR) && (dev >= thr_cfg);
  wire logic time_hit = (trg_w == TRG_TIME) && time_due_r[p];
  wire logic edge_hit = (trg_w == TRG_EDGE) && edge_due_r[p];
  // Static points never save into the buffer path
  wire logic save = rd_v_r && !static_cfg[p] && (thr_hit || time_hit || edge_hit);
  wire logic tmr_hit = (tick && (tper_r + 8'h01 >= tper_cfg)) || tod_hit;
  wire logic tick_end = (tick_cnt_r == 32'(TICK_CYC - 1));

  // ----------------------------------------
  // Per-partner buffer decode
  // ----------------------------------------
  wire logic two = &part_en;
  wire logic [CW-1:0] share = two ? SHARE_TWO : SHARE_ONE;
  wire logic [OW-1:0] sh13 = OW'(share);
  logic [NPART-1:0] enq, cv_hit, push, deq, inflt, full, low, rel_lvl, img_rdy, buf_rdy, spont_ev, cv_wr;
  logic [AW-1:0] hph [NPART];
  logic [AW-1:0] tph [NPART];
  logic [OW-1:0] occ [NPART];
  logic [CW-1:0] cnt_nxt [NPART];

  for (genvar q = 0; q < NPART; q++) begin : g_part
    assign hph[q] = phys(1'(q), head_r[q], two);
    assign tph[q] = phys(1'(q), tail_r[q], two);
    assign occ[q] = OW'(cnt_r[q]) * PCT_ALL;
    assign full[q] = occ[q] >= sh13 * PCT_FULL;
    assign low[q] = occ[q] < sh13 * PCT_LOW;
    assign rel_lvl[q] = occ[q] >= sh13 * PCT_REL;
    // Forced partners see the event only through the image
    assign enq[q] = save && part_en[q] && !forced_r[q];
    assign inflt[q] = tx_valid && !tx_kind && (tx_part == 1'(q));
    assign deq[q] = inflt[q] && tx_ack;
    // An entry already on the wire cannot be overwritten; append instead
    assign cv_hit[q] = !every_cfg[p] && cv_in_r[q][p] && !(inflt[q] && cv_slot_r[q][p] == hph[q]);
    assign cv_wr[q] = enq[q] && cv_hit[q];
    assign push[q] = enq[q] && !cv_hit[q] && (cnt_r[q] < share);
    assign cnt_nxt[q] = cnt_r[q] + CW'(push[q]) - CW'(deq[q]);
    assign spont_ev[q] = enq[q] && spont_cfg[p];
    assign img_rdy[q] = img_pend_r[q] && link_up[q];
    assign buf_rdy[q] = rel_r[q] && link_up[q] && (cnt_r[q] != '0);
  end

  wire logic qi = !img_rdy[0];
  wire logic qb = !buf_rdy[0];

  // ----------------------------------------
  // Timebase prescaler
  // ----------------------------------------
  // Counter sits at the top level parameter so simulation can shorten it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick <= 1'b0;
      tper_r <= '0;
    end else begin
      tick_cnt_r <= tick_end ? '0 : tick_cnt_r + 32'h1;
      tick <= tick_end;
      if (tick) begin
        tper_r <= tmr_hit ? '0 : tper_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Scan cycle over controller memory
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ph_r <= PH_FAST;
      idx_r <= '0;
      jobs_r <= '0;
      nptr_r <= '0;
      idle_r <= '0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      rd_v_r <= 1'b0;
      rd_pt_r <= '0;
    end else begin
      mem_rd <= rd_go;
      mem_wr <= clr_go || wr_go;
      // Read data stands in the cycle after the strobe, so qualify one cycle late
      rd_v_r <= mem_rd;
      rd_pt_r <= mem_addr[PW-1:0];
      if (rd_go) begin
        mem_addr <= RD_BASE + ADW'(rd_pt_w);
      end else if (clr_go) begin
        mem_addr <= TAG_BASE + ADW'(clr_sel);
        mem_wdata <= '0;
      end else if (wr_go) begin
        mem_addr <= WR_BASE + ADW'(wr_sel);
        mem_wdata <= wr_val_r[wr_sel];
      end
      unique case (ph_r)
        PH_FAST: begin
          idx_r <= fast_end ? '0 : idx_r + 4'h1;
          jobs_r <= '0;
          if (fast_end) begin
            ph_r <= PH_WRITE;
          end
        end
        PH_WRITE: begin
          if (wr_go) begin
            jobs_r <= jobs_r + 4'h1;
          end else if (!clr_go) begin
            ph_r <= PH_NORM;
            jobs_r <= '0;
          end
        end
        PH_NORM: begin
          if (norm_end) begin
            ph_r <= PH_IDLE;
            idle_r <= '0;
            idx_r <= '0;
          end else begin
            idx_r <= idx_r + 4'h1;
            nptr_r <= nptr_r + 3'h1;
            jobs_r <= jobs_r + JW'(norm_rd);
          end
        end
        PH_IDLE: begin
          if (idle_r >= idle_cfg) begin
            ph_r <= PH_FAST;
          end else begin
            idle_r <= idle_r + 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Image memory and per-point trigger state
  // ----------------------------------------
  // Sets are written after clears so a same-cycle event is kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NPT; i++) begin
        img_r[i] <= '0;
        last_r[i] <= '0;
        wr_val_r[i] <= '0;
      end
      tag_q_r <= '0;
      edge_due_r <= '0;
      time_due_r <= '0;
      clr_pend_r <= '0;
      wr_pend_r <= '0;
    end else begin
      tag_q_r <= trig_tag;
      if (rd_v_r) begin
        img_r[p] <= v;
      end
      if (save) begin
        last_r[p] <= v;
        edge_due_r[p] <= 1'b0;
        time_due_r[p] <= 1'b0;
      end
      edge_due_r <= (save ? edge_due_r & ~(NPT'(1) << p) : edge_due_r) | (trig_tag & ~tag_q_r);
      if (tmr_hit) begin
        time_due_r <= '1;
      end
      if (clr_go) begin
        clr_pend_r[clr_sel] <= 1'b0;
      end
      // Input-area tags are left alone; the controller clears those
      if (save && edge_hit && tag_mem_cfg[p]) begin
        clr_pend_r[p] <= 1'b1;
      end
      if (wr_go) begin
        wr_pend_r[wr_sel] <= 1'b0;
      end
      if (wr_req) begin
        wr_pend_r[wr_pt] <= 1'b1;
        wr_val_r[wr_pt] <= wr_val;
      end
    end
  end

  // ----------------------------------------
  // Send buffer storage
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    for (int q = 0; q < NPART; q++) begin
      if (push[q]) begin
        bpt_r[tph[q]] <= p;
        bval_r[tph[q]] <= v;
      end else if (cv_wr[q]) begin
        bval_r[cv_slot_r[q][p]] <= v;
      end
    end
  end

  // ----------------------------------------
  // Send buffer control per partner
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int q = 0; q < NPART; q++) begin
        head_r[q] <= '0;
        tail_r[q] <= '0;
        cnt_r[q] <= '0;
        cv_in_r[q] <= '0;
        for (int i = 0; i < NPT; i++) begin
          cv_slot_r[q][i] <= '0;
        end
      end
      forced_r <= '0;
      rel_r <= '0;
    end else begin
      for (int q = 0; q < NPART; q++) begin
        cnt_r[q] <= cnt_nxt[q];
        if (deq[q]) begin
          head_r[q] <= incp(head_r[q], share);
          if (cv_slot_r[q][bpt_r[hph[q]]] == hph[q]) begin
            cv_in_r[q][bpt_r[hph[q]]] <= 1'b0;
          end
        end
        if (push[q]) begin
          tail_r[q] <= incp(tail_r[q], share);
          if (!every_cfg[p]) begin
            cv_in_r[q][p] <= 1'b1;
            cv_slot_r[q][p] <= tph[q];
          end
        end
        if (full[q]) begin
          forced_r[q] <= 1'b1;
        end else if (link_up[q] && low[q]) begin
          forced_r[q] <= 1'b0;
        end
        if (query[q] || spont_ev[q] || rel_lvl[q]) begin
          rel_r[q] <= 1'b1;
        end else if (cnt_nxt[q] == '0) begin
          rel_r[q] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit toward the partner
  // ----------------------------------------
  // Image dump has priority so the process image leads the buffered frames
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_part <= 1'b0;
      tx_kind <= 1'b0;
      tx_pt <= '0;
      tx_val <= '0;
      img_pend_r <= '0;
      for (int q = 0; q < NPART; q++) begin
        img_idx_r[q] <= '0;
      end
    end else begin
      if (!tx_valid) begin
        if (|img_rdy) begin
          tx_valid <= 1'b1;
          tx_kind <= 1'b1;
          tx_part <= qi;
          tx_pt <= img_idx_r[qi];
          tx_val <= img_r[img_idx_r[qi]];
        end else if (|buf_rdy) begin
          tx_valid <= 1'b1;
          tx_kind <= 1'b0;
          tx_part <= qb;
          tx_pt <= bpt_r[hph[qb]];
          tx_val <= bval_r[hph[qb]];
        end
      end else if (tx_ack) begin
        tx_valid <= 1'b0;
        if (tx_kind) begin
          img_idx_r[tx_part] <= img_idx_r[tx_part] + 3'h1;
          if (img_idx_r[tx_part] == LAST_PT) begin
            img_pend_r[tx_part] <= 1'b0;
          end
        end
      end
      for (int q = 0; q < NPART; q++) begin
        if (query[q] || spont_ev[q]) begin
          img_pend_r[q] <= 1'b1;
        end
      end
    end
  end

  assign forced_mode = forced_r;
endmodule
`default_nettype wire

// ---- esb_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker for the event buffer block
// ----------------------------------------
module esb_chk #(
  parameter int TICK_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [esb_pkg::NPT-1:0] fast_cfg,
  input wire logic [esb_pkg::JW-1:0] max_wr_cfg,
  input wire logic [esb_pkg::JW-1:0] max_rd_cfg,
  input wire logic [esb_pkg::ADW-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [esb_pkg::VW-1:0] mem_wdata,
  input wire logic [esb_pkg::NPART-1:0] link_up,
  input wire logic tx_valid,
  input wire logic tx_part,
  input wire logic tx_kind,
  input wire logic [esb_pkg::PW-1:0] tx_pt,
  input wire logic [esb_pkg::VW-1:0] tx_val,
  input wire logic tx_ack,
  input wire logic tick
);
  import esb_pkg::*;
  logic [31:0] tcnt_r, tcnt_nxt;
  logic tseen_r;
  logic [5:0] wcnt_r, wcnt_nxt, ncnt_r, ncnt_nxt;
  wire wr_job = mem_wr && mem_addr[7:6] == 2'h1;
  wire rd_fast = mem_rd && fast_cfg[mem_addr[PW-1:0]];
  // A fast read opens each scan, so counts are only trusted while some point is fast
  assign tcnt_nxt = tick ? 32'h0 : tcnt_r + 32'h1;
  assign wcnt_nxt = mem_rd ? 6'h0 : wcnt_r + {5'h0, wr_job};
  assign ncnt_nxt = (rd_fast || wr_job) ? 6'h0 : ncnt_r + {5'h0, mem_rd};
  // Cycle and job counters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tcnt_r <= '0;
      tseen_r <= 1'b0;
      wcnt_r <= '0;
      ncnt_r <= '0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tseen_r <= tseen_r | tick;
      wcnt_r <= wcnt_nxt;
      ncnt_r <= ncnt_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_tick_period: assert property (tseen_r |-> (tick == (tcnt_r == TICK_CYC - 1)))
    else $error("timebase pulse off period");
  a_wr_job_limit: assert property (fast_cfg != '0 |-> wcnt_r <= 6'(max_wr_cfg))
    else $error("too many write jobs in one scan");
  a_rd_job_limit: assert property (fast_cfg != '0 |-> ncnt_r <= 6'(max_rd_cfg))
    else $error("too many normal reads in one scan");
  a_tag_clear_zero: assert property (mem_wr && mem_addr[7:6] == 2'h2 |-> mem_wdata == '0)
    else $error("tag clear writes nonzero");
  a_rd_point_window: assert property (mem_rd |-> !mem_wr && mem_addr < NPT)
    else $error("read outside point window");
  a_tx_hold_frame: assert property (tx_valid && !tx_ack |=> tx_valid && $stable({tx_part, tx_kind, tx_pt, tx_val}))
    else $error("frame changed before ack");
  a_ack_drops_frame: assert property (tx_valid && tx_ack |=> !tx_valid)
    else $error("frame kept after ack");
  a_send_link_up: assert property ($rose(tx_valid) |-> (tx_part ? $past(link_up[1]) : $past(link_up[0])))
    else $error("frame offered on a dead link");
endmodule
bind esb_top esb_chk #(.TICK_CYC(TICK_CYC)) u_chk (.sys_clk, .rstn, .fast_cfg, .max_wr_cfg, .max_rd_cfg,
  .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .link_up, .tx_valid, .tx_part, .tx_kind, .tx_pt, .tx_val, .tx_ack, .tick);
`default_nettype wire

// ---- esb_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Controller memory behind the scan port
// ----------------------------------------
module esb_mem_model (
  input wire logic sys_clk,
  input wire logic [esb_pkg::ADW-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [esb_pkg::VW-1:0] mem_wdata,
  output logic [esb_pkg::VW-1:0] mem_rdata,
  input wire logic [esb_pkg::NPT-1:0] tag_set,
  input wire logic [esb_pkg::NPT-1:0] tag_clr,
  output logic [esb_pkg::NPT-1:0] trig_tag
);
  import esb_pkg::*;
  logic [VW-1:0] val [NPT];
  logic [VW-1:0] wval [NPT];
  wire [NPT-1:0] dev_clr = (mem_wr && mem_addr[7:6] == 2'h2) ? (8'h01 << mem_addr[PW-1:0]) : 8'h00;
  initial begin
    mem_rdata = '0;
    trig_tag = '0;
  end
  // Data only in the cycle after a read; otherwise junk, so stale data cannot pass
  always @(posedge sys_clk) begin
    mem_rdata <= mem_rd ? val[mem_addr[PW-1:0]] : ~mem_rdata;
    if (mem_wr && mem_addr[7:6] == 2'h1) begin
      wval[mem_addr[PW-1:0]] <= mem_wdata;
    end
    trig_tag <= (trig_tag & ~dev_clr & ~tag_clr) | tag_set;
  end
endmodule
`default_nettype wire

// ---- esb_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module esb_top_tb;
  import esb_pkg::*;
  logic sys_clk, rstn, tod_hit, wr_req, tx_ack, mem_rd, mem_wr, tx_valid, tx_part, tx_kind, tick;
  logic [NPT-1:0] static_cfg, every_cfg, spont_cfg, fast_cfg, tag_mem_cfg, trig_tag, tag_set, tag_clr;
  logic [2*NPT-1:0] trg_cfg;
  logic [VW-1:0] thr_cfg, wr_val, mem_wdata, mem_rdata, tx_val;
  logic [IW-1:0] tper_cfg, idle_cfg;
  logic [JW-1:0] max_wr_cfg, max_rd_cfg;
  logic [PW-1:0] wr_pt, tx_pt;
  logic [ADW-1:0] mem_addr;
  logic [NPART-1:0] part_en, link_up, query, forced_mode;
  logic [VW-1:0] img [NPT];
  int n_fail, cmp_count, k;
  esb_top #(.TICK_CYC(20)) uut (.sys_clk, .rstn, .static_cfg, .every_cfg, .spont_cfg, .fast_cfg, .tag_mem_cfg,
    .trg_cfg, .thr_cfg, .tper_cfg, .tod_hit, .max_wr_cfg, .max_rd_cfg, .idle_cfg, .trig_tag, .wr_req, .wr_pt,
    .wr_val, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .part_en, .link_up, .query, .tx_valid,
    .tx_part, .tx_kind, .tx_pt, .tx_val, .tx_ack, .forced_mode, .tick);
  esb_mem_model mdl (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .tag_set, .tag_clr,
    .trig_tag);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task bad(input string m);
    n_fail++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) bad(m);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task pulse(input logic [NPT-1:0] m);
    tag_set <= m;
    @(posedge sys_clk);
    tag_set <= '0;
  endtask
  task ask;
    query <= 2'h1;
    @(posedge sys_clk);
    query <= 2'h0;
  endtask
  // Waits for a frame, compares it, then acks it for exactly one cycle
  task get(input logic kd, input logic [PW-1:0] p, input logic [VW-1:0] v);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (tx_valid !== 1'b1 && i < 3000) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 3000) begin
      bad("no frame");
      wrap_up();
    end
    cmp_count++;
    if ({tx_kind, tx_pt, tx_val} !== {kd, p, v}) bad("frame mismatch");
    @(posedge sys_clk);
    tx_ack <= 1'b1;
    @(posedge sys_clk);
    tx_ack <= 1'b0;
  endtask
  task dump;
    for (int p = 0; p < NPT; p++) get(1'b1, p[PW-1:0], img[p]);
  endtask
  task quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge sys_clk);
      seen = seen | (tx_valid !== 1'b0);
    end
    cmp_count++;
    if (seen) bad("unexpected frame");
    @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0; tod_hit = 1'b0; wr_req = 1'b0; tx_ack = 1'b0; tag_set = '0; tag_clr = '0;
    static_cfg = 8'h01; every_cfg = 8'h00; spont_cfg = 8'h03; fast_cfg = 8'h0f; tag_mem_cfg = 8'hfc;
    trg_cfg = 16'hfffa; thr_cfg = 16'h0100; tper_cfg = 8'h01; idle_cfg = 8'h04;
    max_wr_cfg = 4'h1; max_rd_cfg = 4'h2; wr_pt = 3'h0; wr_val = 16'h0000;
    part_en = 2'h1; link_up = 2'h1; query = 2'h0; n_fail = 0; cmp_count = 0;
    for (k = 0; k < NPT; k++) begin
      img[k] = 16'h0a00 + VW'(k);
      mdl.val[k] = img[k];
    end
    cyc(4);
    rstn <= 1'b1;
    // Static point never queues; spontaneous event sends image then entry
    cyc(200);
    pulse(8'h01);
    quiet(150);
    pulse(8'h02);
    dump();
    get(1'b0, 3'h1, img[1]);
    quiet(100);
    chk(trig_tag[1] === 1'b1, "input tag cleared by device");
    tag_clr <= 8'h03;
    @(posedge sys_clk);
    tag_clr <= 8'h00;
    $display("test static_spont done");
    // Every-value entries held while the link is down, then oldest first
    // Point 0 stays static: its tag edge from the first test is still armed
    link_up <= 2'h0; spont_cfg <= 8'h00; every_cfg <= 8'h02; tag_mem_cfg <= 8'hff;
    for (k = 1; k < 4; k++) begin
      mdl.val[1] <= VW'(16'h1110 * k);
      cyc(120);
      pulse(8'h02);
      cyc(60);
      chk(trig_tag[1] === 1'b0, "memory tag not cleared");
    end
    img[1] = 16'h3330;
    quiet(50);
    link_up <= 2'h1;
    ask();
    dump();
    for (k = 1; k < 4; k++) get(1'b0, 3'h1, VW'(16'h1110 * k));
    quiet(100);
    $display("test every_value done");
    // Current-value class keeps only the newest entry
    link_up <= 2'h0; every_cfg <= 8'h00; trg_cfg <= 16'hffef;
    for (k = 1; k < 3; k++) begin
      mdl.val[2] <= 16'h0c00 + VW'(k);
      cyc(120);
      pulse(8'h04);
      cyc(60);
    end
    img[2] = 16'h0c02;
    link_up <= 2'h1;
    ask();
    dump();
    get(1'b0, 3'h2, 16'h0c02);
    quiet(100);
    $display("test current_value done");
    // Time trigger fills to forced mode; drain shows the 50% exit
    link_up <= 2'h0; every_cfg <= 8'h08; trg_cfg <= 16'hff7f; tod_hit <= 1'b1;
    @(posedge sys_clk);
    tod_hit <= 1'b0;
    k = 0;
    while (forced_mode[0] !== 1'b1 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(forced_mode[0] === 1'b1, "forced mode not entered");
    if (k == 3000) wrap_up();
    @(posedge sys_clk);
    trg_cfg <= 16'hffff;
    link_up <= 2'h1;
    for (k = 0; k < 29; k++) begin
      get(1'b0, 3'h3, img[3]);
      if (k == 12 || k == 13) begin
        cyc(3);
        chk(forced_mode[0] === (k == 12), "forced exit at wrong fill");
      end
    end
    quiet(100);
    $display("test forced_mode done");
    // Writes queued back to back trickle out one per scan
    // Lower the read quota only just after a scan opens, so no scan sees two quotas
    k = 0;
    while (!(mem_rd === 1'b1 && mem_addr === RD_BASE) && k < 1000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 1000) begin
      bad("scan stalled");
      wrap_up();
    end
    max_rd_cfg <= 4'h1; idle_cfg <= 8'h08;
    for (k = 4; k < 7; k++) begin
      wr_req <= 1'b1;
      wr_pt <= k[PW-1:0];
      wr_val <= 16'hb000 + VW'(k);
      @(posedge sys_clk);
    end
    wr_req <= 1'b0;
    mdl.val[5] <= 16'h5555;
    img[5] = 16'h5555;
    cyc(300);
    for (k = 4; k < 7; k++) chk(mdl.wval[k] === 16'hb000 + VW'(k), "write job lost");
    ask();
    dump();
    $display("test writes_reads done");
    wrap_up();
  end
endmodule
`default_nettype wire
